/* File: common/afsp_defines.vh */
`ifndef AFSP_DEFINES_VH
`define AFSP_DEFINES_VH

`define AFSP_RESULT_W 12
`define AFSP_TOP_BIT 11
`define AFSP_TEN_BIT 10
`define AFSP_ZERO_CODE 12'h000
`define AFSP_FULL_CODE 12'hfff
`define AFSP_LOW_MASK 12'h7ff
`define AFSP_TOP_MASK 12'h800
`define AFSP_PIPE_STAGES 3
`define AFSP_BUF_DEPTH 2
`define AFSP_BUF_PTR_W 1
`define AFSP_SYNC_W 20
`define AFSP_FLAG_LOW 1'b0

`endif

/* File: design/afsp_buffer.v */
`timescale 1ns/100ps
`default_nettype none
`include "afsp_defines.vh"

module afsp_buffer #(
  parameter WIDTH = 14,
  parameter DEPTH = `AFSP_BUF_DEPTH,
  parameter PTR_W = `AFSP_BUF_PTR_W
) (
  input wire mclk,
  input wire rst_b,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_W-1:0] wrPtr;
  reg [PTR_W-1:0] rdPtr;
  reg [PTR_W:0] count;
  wire doPush;
  wire doPop;
  integer i;

  // Full and empty come straight from the occupancy count
  assign inReady = (count != DEPTH[PTR_W:0]);
  assign outValid = (count != {(PTR_W+1){1'b0}});
  assign outData = store[rdPtr];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;

  // Pointers wrap at the depth, count tracks push minus pop
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= {PTR_W{1'b0}};
      rdPtr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
        count <= count + 1'b1;
      end else if (doPop && !doPush) begin
        count <= count - 1'b1;
      end
    end
  end

  // Storage written only on an accepted push
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        store[i] <= {WIDTH{1'b0}};
      end
    end else if (doPush) begin
      store[wrPtr] <= inData;
    end
  end

endmodule
`default_nettype wire

/* File: design/afsp_sync_unused_placeholder_removed.v */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: design/afsp_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "afsp_defines.vh"

module afsp_top #(
  parameter RESULT_W = `AFSP_RESULT_W,
  parameter STAGES = `AFSP_PIPE_STAGES
) (
  input wire mclk,
  input wire rst_b,
  // Conversion clock pin, sampled and edge detected
  input wire convClk,
  // Quantised front-end value and its range comparators
  input wire [RESULT_W-1:0] sampleCode,
  input wire belowBottom,
  input wire aboveTop,
  // Inversion pads: level and whether anything drives it
  input wire msbInvertPin,
  input wire msbInvertDriven,
  input wire lsbInvertPin,
  input wire lsbInvertDriven,
  // Serial port pins from the host
  input wire shiftClk,
  input wire shiftLoadN,
  // Parallel consumer acceptance, same clock domain
  input wire resultReady,
  output reg [RESULT_W-1:0] resultWord,
  output reg resultValid,
  output reg underflowFlag,
  output reg overflowFlag,
  output reg samplePhase,
  output reg conversionStall,
  output reg serialResultOut
);

  localparam ITEM_W = RESULT_W + 2;

  // Control pin positions in their synchroniser
  localparam CI_CONV = 0;
  localparam CI_SCLK = 1;
  localparam CI_LOAD = 2;
  localparam CTRL_W = 3;

  // Format pin positions in their synchroniser
  localparam FI_MSB = 0;
  localparam FI_LSB = 1;
  localparam FMT_W = 2;

  // Front-end word: code, below-bottom flag, above-top flag
  localparam DI_UNDER = RESULT_W;
  localparam DI_OVER = RESULT_W + 1;
  localparam DATA_W = RESULT_W + 2;

  // Idle pin levels: load strobe (top position) released, both clocks low
  localparam [CTRL_W-1:0] CTRL_IDLE = {1'b1, {(CTRL_W-1){1'b0}}};

  // Raw pin groups and their two synchroniser stages
  wire [CTRL_W-1:0] ctrlIn;
  reg [CTRL_W-1:0] ctrlFirst;
  reg [CTRL_W-1:0] ctrlSecond;
  wire [FMT_W-1:0] fmtIn;
  reg [FMT_W-1:0] fmtFirst;
  reg [FMT_W-1:0] fmtSecond;
  wire [DATA_W-1:0] dataIn;
  reg [DATA_W-1:0] dataFirst;
  reg [DATA_W-1:0] dataSecond;

  // Edge history of the two clock pins
  reg convPrev;
  reg sclkPrev;

  // One-cycle enables and synchronised views
  wire convNow;
  wire convFall;
  wire convRise;
  wire sclkRise;
  wire loadActive;
  wire msbInvert;
  wire lsbInvert;
  wire underNow;
  wire overNow;
  wire [RESULT_W-1:0] codeNow;

  // Conversion pipeline, one slot per falling conversion edge
  reg [RESULT_W-1:0] stageCode [0:STAGES-1];
  reg [STAGES-1:0] stageUnder;
  reg [STAGES-1:0] stageOver;
  reg [STAGES-1:0] stageValid;
  reg pushPending;
  wire advance;
  integer k;

  // Buffer handshake and unpacked fields
  wire [ITEM_W-1:0] bufInData;
  wire bufInValid;
  wire bufInReady;
  wire [ITEM_W-1:0] bufOutData;
  wire bufOutValid;
  wire bufOutReady;
  wire [RESULT_W-1:0] rawCode;
  wire rawUnder;
  wire rawOver;

  // Formatting and serial shift state
  reg [RESULT_W-1:0] next_resultWord;
  reg [RESULT_W-1:0] clampCode;
  reg [RESULT_W-1:0] shiftReg;
  reg [RESULT_W-1:0] next_shiftReg;

  // Pad pull-downs make an undriven inversion input read low
  assign ctrlIn[CI_CONV] = convClk;
  assign ctrlIn[CI_SCLK] = shiftClk;
  assign ctrlIn[CI_LOAD] = shiftLoadN;
  assign fmtIn[FI_MSB] = msbInvertPin & msbInvertDriven;
  assign fmtIn[FI_LSB] = lsbInvertPin & lsbInvertDriven;
  assign dataIn = {aboveTop, belowBottom, sampleCode};

  // Control synchronisers leave reset at idle, so no false load follows
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlFirst <= CTRL_IDLE;
      ctrlSecond <= CTRL_IDLE;
    end else begin
      ctrlFirst <= ctrlIn;
      ctrlSecond <= ctrlFirst;
    end
  end

  // Format synchronisers leave reset at the pull-down level
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fmtFirst <= {FMT_W{1'b0}};
      fmtSecond <= {FMT_W{1'b0}};
    end else begin
      fmtFirst <= fmtIn;
      fmtSecond <= fmtFirst;
    end
  end

  // Front-end word synchroniser; only read on a falling conversion edge
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dataFirst <= {DATA_W{1'b0}};
      dataSecond <= {DATA_W{1'b0}};
    end else begin
      dataFirst <= dataIn;
      dataSecond <= dataFirst;
    end
  end

  // Synchronised views of the pins
  assign convNow = ctrlSecond[CI_CONV];
  assign loadActive = ~ctrlSecond[CI_LOAD];
  assign msbInvert = fmtSecond[FI_MSB];
  assign lsbInvert = fmtSecond[FI_LSB];
  assign underNow = dataSecond[DI_UNDER];
  assign overNow = dataSecond[DI_OVER];
  assign codeNow = dataSecond[RESULT_W-1:0];

  // Conversion clock edge history
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      convPrev <= 1'b0;
    end else begin
      convPrev <= convNow;
    end
  end

  // Shift clock edge history
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= ctrlSecond[CI_SCLK];
    end
  end

  // One-cycle enables from the clock pins
  assign convFall = convPrev & ~convNow;
  assign convRise = ~convPrev & convNow;
  assign sclkRise = ~sclkPrev & ctrlSecond[CI_SCLK];

  // Tracking while the conversion clock is high, hold after its fall
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      samplePhase <= 1'b0;
    end else begin
      samplePhase <= convNow;
    end
  end

  // A conversion is skipped while the buffer still refuses a word
  assign advance = convFall & ~pushPending;

  // Capture and pipeline, one stage per falling conversion edge
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (k = 0; k < STAGES; k = k + 1) begin
        stageCode[k] <= `AFSP_ZERO_CODE;
      end
      stageUnder <= {STAGES{1'b0}};
      stageOver <= {STAGES{1'b0}};
      stageValid <= {STAGES{1'b0}};
    end else if (advance) begin
      // Value present at the falling sample phase is the one held
      stageCode[0] <= codeNow;
      stageUnder[0] <= underNow;
      stageOver[0] <= overNow;
      stageValid[0] <= 1'b1;
      for (k = 1; k < STAGES; k = k + 1) begin
        stageCode[k] <= stageCode[k-1];
        stageUnder[k] <= stageUnder[k-1];
        stageOver[k] <= stageOver[k-1];
        stageValid[k] <= stageValid[k-1];
      end
    end
  end

  // Last stage waits for the rising edge to enter the buffer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pushPending <= 1'b0;
    end else if (advance && stageValid[STAGES-2]) begin
      pushPending <= 1'b1;
    end else if (bufInValid && bufInReady) begin
      pushPending <= 1'b0;
    end
  end

  // Report a conversion lost to a full buffer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      conversionStall <= 1'b0;
    end else begin
      conversionStall <= convFall & pushPending;
    end
  end

  // Offered word: code plus both range flags
  assign bufInValid = pushPending & convRise;
  assign bufInData = {stageOver[STAGES-1], stageUnder[STAGES-1], stageCode[STAGES-1]};

  afsp_buffer #(
    .WIDTH(ITEM_W),
    .DEPTH(`AFSP_BUF_DEPTH),
    .PTR_W(`AFSP_BUF_PTR_W)
  ) resultBuffer (
    .mclk(mclk),
    .rst_b(rst_b),
    .inData(bufInData),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .outData(bufOutData),
    .outValid(bufOutValid),
    .outReady(bufOutReady)
  );

  // Output latch opens when empty or when the consumer takes the word
  assign bufOutReady = ~resultValid | resultReady;
  assign rawCode = bufOutData[RESULT_W-1:0];
  assign rawUnder = bufOutData[RESULT_W];
  assign rawOver = bufOutData[RESULT_W+1];

  // Range clamp ahead of formatting
  always @* begin
    clampCode = rawCode;
    if (rawUnder) begin
      clampCode = `AFSP_ZERO_CODE;
    end else if (rawOver) begin
      clampCode = `AFSP_FULL_CODE;
    end
  end

  // Format with the inversion pair; straight binary when neither is set
  always @* begin
    next_resultWord = clampCode;
    if (msbInvert) begin
      next_resultWord = next_resultWord ^ `AFSP_TOP_MASK;
    end
    if (lsbInvert) begin
      next_resultWord = next_resultWord ^ `AFSP_LOW_MASK;
    end
  end

  // Output register; inversion changes show only when it loads
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      resultWord <= `AFSP_ZERO_CODE;
    end else if (bufOutValid && bufOutReady) begin
      resultWord <= next_resultWord;
    end
  end

  // Valid holds until the consumer takes the word
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      resultValid <= 1'b0;
    end else if (bufOutValid && bufOutReady) begin
      resultValid <= 1'b1;
    end else if (resultReady) begin
      resultValid <= 1'b0;
    end
  end

  // Underflow flag passes untouched by the inversion inputs
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      underflowFlag <= `AFSP_FLAG_LOW;
    end else if (bufOutValid && bufOutReady) begin
      underflowFlag <= rawUnder;
    end
  end

  // Overflow flag passes untouched by the inversion inputs
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overflowFlag <= `AFSP_FLAG_LOW;
    end else if (bufOutValid && bufOutReady) begin
      overflowFlag <= rawOver;
    end
  end

  // Serial shift register: level load wins over shifting
  always @* begin
    next_shiftReg = shiftReg;
    if (loadActive) begin
      next_shiftReg = resultWord;
    end else if (sclkRise) begin
      // Shift only with the strobe released high
      next_shiftReg = {shiftReg[`AFSP_TEN_BIT:0], 1'b0};
    end
  end

  // Shift register state
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shiftReg <= `AFSP_ZERO_CODE;
    end else begin
      shiftReg <= next_shiftReg;
    end
  end

  // Serial pin follows the top bit of the next shift register value
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      serialResultOut <= 1'b0;
    end else begin
      serialResultOut <= next_shiftReg[`AFSP_TOP_BIT];
    end
  end

endmodule
`default_nettype wire

/* File: tb/afsp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module afsp_host_model (
  input wire logic serialResultOut,
  output logic shiftClk,
  output logic shiftLoadN
);
  // Idle: strobe released, shift clock parked low
  initial begin
    shiftClk = 1'b0;
    shiftLoadN = 1'b1;
  end
  // One framed readout; half is the shift clock half period in ns
  task automatic read_word(input int half, output logic [11:0] w);
    int i;
    shiftLoadN = 1'b0;
    #100;
    shiftClk = 1'b1;
    #(half);
    shiftClk = 1'b0;
    #100;
    shiftLoadN = 1'b1;
    #100;
    for (i = 11; i >= 0; i--) begin
      w[i] = serialResultOut;
      if (i > 0) begin
        shiftClk = 1'b1;
        #(half);
        shiftClk = 1'b0;
        #(half);
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/afsp_top_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module afsp_top_monitor #(
  parameter RESULT_W = 12
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic convClk,
  input wire logic shiftClk,
  input wire logic shiftLoadN,
  input wire logic resultReady,
  input wire logic [RESULT_W-1:0] resultWord,
  input wire logic resultValid,
  input wire logic underflowFlag,
  input wire logic samplePhase,
  input wire logic conversionStall,
  input wire logic serialResultOut
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // Underflow word sits at a full-scale code in every format
  chk_under_code:
    assert property (underflowFlag |-> (resultWord[RESULT_W-2:0] == 0 ||
      &resultWord[RESULT_W-2:0])) else $error("underflow word off full scale");
  // Serial pin follows the top bit while the load strobe is held
  chk_load_top:
    assert property ((!shiftLoadN && $stable(resultWord))[*5] |->
      serialResultOut == resultWord[RESULT_W-1]) else $error("serial top bit wrong");
  chk_load_hold:
    assert property ((!shiftLoadN && $stable(resultWord))[*6] |-> $stable(serialResultOut))
      else $error("serial pin moved during load");
  chk_idle_hold:
    assert property ((shiftLoadN && $stable(shiftClk))[*6] |-> $stable(serialResultOut))
      else $error("serial pin moved without shift edge");
  // Sample phase tracks the conversion clock level
  chk_phase_high:
    assert property (convClk[*5] |-> samplePhase) else $error("phase not tracking");
  chk_phase_low:
    assert property (!convClk[*5] |-> !samplePhase) else $error("phase not holding");
  // Held word and refusal pulse
  chk_valid_hold:
    assert property (resultValid && !resultReady |=> resultValid && $stable(resultWord)
      && $stable(underflowFlag)) else $error("word lost under stall");
  chk_stall_pulse:
    assert property (conversionStall |-> !samplePhase ##1 !conversionStall)
      else $error("stall pulse wrong");
  cover property (resultValid && resultReady);
  cover property (underflowFlag && resultValid);
  cover property (conversionStall);
  cover property ($fell(shiftLoadN));
endmodule
bind afsp_top afsp_top_monitor #(.RESULT_W(RESULT_W)) u_mon (.mclk, .rst_b, .convClk,
  .shiftClk, .shiftLoadN, .resultReady, .resultWord, .resultValid, .underflowFlag,
  .samplePhase, .conversionStall, .serialResultOut);
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic convClk = 1'b1;
  logic [11:0] sampleCode = 12'h000;
  logic belowBottom = 1'b0, aboveTop = 1'b0, resultReady = 1'b1, rMode = 1'b0;
  logic msbInvertPin = 1'b0, msbInvertDriven = 1'b1;
  logic lsbInvertPin = 1'b0, lsbInvertDriven = 1'b1;
  logic checkOn = 1'b1;
  wire logic shiftClk, shiftLoadN, resultValid, underflowFlag, overflowFlag;
  wire logic samplePhase, conversionStall, serialResultOut;
  wire logic [11:0] resultWord;
  int bad_count = 0, n_compared = 0, seed = 32'hd84f_9792, stalls = 0, i, w;
  logic [13:0] expQ[$];
  logic [13:0] e, lastExp;
  logic [11:0] rd;
  afsp_top #(.RESULT_W(12), .STAGES(3)) u_dut (.mclk, .rst_b, .convClk, .sampleCode,
    .belowBottom, .aboveTop, .msbInvertPin, .msbInvertDriven, .lsbInvertPin,
    .lsbInvertDriven, .shiftClk, .shiftLoadN, .resultReady, .resultWord, .resultValid,
    .underflowFlag, .overflowFlag, .samplePhase, .conversionStall, .serialResultOut);
  afsp_host_model u_host (.serialResultOut, .shiftClk, .shiftLoadN);
  // Clock
  initial begin
    forever #4 mclk = ~mclk;
  end
  // Expected flags and word from a raw sample and the inversion levels
  function automatic logic [13:0] fmt(logic [13:0] s, logic m, logic l);
    logic [11:0] x;
    x = s[13] ? 12'h000 : s[12] ? 12'hfff : s[11:0];
    return {s[13], s[12] & !s[13], x ^ {m, {11{l}}}};
  endfunction
  task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Random consumer acceptance
  always @(posedge mclk) begin
    #1;
    if (rMode) resultReady = ($random(seed) & 3) != 0;
  end
  // Check every word accepted while checkOn is high, and count refusals
  always @(posedge mclk) begin
    if (conversionStall === 1'b1) stalls++;
    if (rst_b && checkOn && resultValid === 1'b1 && resultReady) begin
      e = expQ.pop_front();
      lastExp = fmt(e, msbInvertPin & msbInvertDriven, lsbInvertPin & lsbInvertDriven);
      cmp({underflowFlag, overflowFlag, resultWord}, lastExp);
    end
  end
  // Conversion cycles of 16 mclk; inversions change only while the clock is low
  task automatic conv_run(input int n, input logic [3:0] inv);
    int k, r;
    for (k = 0; k < n; k++) begin
      convClk = 1'b0;
      expQ.push_back({belowBottom, aboveTop, sampleCode});
      if (k == 0) {msbInvertPin, lsbInvertPin, msbInvertDriven, lsbInvertDriven} = inv;
      rMode = checkOn && (k < n - 1);
      if (!rMode) resultReady = checkOn;
      repeat (8) @(posedge mclk);
      #1 convClk = 1'b1;
      r = $random(seed) & 7;
      belowBottom = (r == 0);
      aboveTop = (r == 1);
      sampleCode = 12'($random(seed));
      if (k == 1) sampleCode = 12'h000;
      if (k == 2) sampleCode = 12'hfff;
      repeat (8) @(posedge mclk);
      #1;
    end
  endtask
  task automatic drain;
    for (w = 0; w < 80 && resultValid !== 1'b0; w++) @(posedge mclk);
    if (w == 80) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // Main sequence: formats, serial readouts, then fill and drain the buffer
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst_b = 1'b1;
    // Let the conversion clock pin reach the edge detector high first
    repeat (4) @(posedge mclk);
    #1;
    for (i = 0; i < 5; i++) conv_run(10, (i == 4) ? 4'b1100 : {i[1:0], 2'b11});
    conv_run(6, 4'b1011);
    drain();
    u_host.read_word(32, rd);
    cmp({2'b00, rd}, {2'b00, lastExp[11:0]});
    msbInvertPin = ~msbInvertPin;
    lsbInvertPin = ~lsbInvertPin;
    u_host.read_word(32, rd);
    cmp({2'b00, rd}, {2'b00, lastExp[11:0]});
    checkOn = 1'b0;
    conv_run(8, 4'b0011);
    cmp({13'h0000, stalls != 0}, 14'h0001);
    resultReady = 1'b1;
    drain();
    report_and_stop();
  end
endmodule
`default_nettype wire
